/* File: ugsr_defs.svh */
`ifndef UGSR_DEFS_SVH
`define UGSR_DEFS_SVH
`define UGSR_ADDR_W 12
`define UGSR_OFF_STATUS 12'h804
`define UGSR_OFF_CLEAR 12'h808
`define UGSR_OFF_SET 12'h80c
`define UGSR_OFF_VERSION 12'h818
`define UGSR_OFF_FEATURES 12'h81c
`define UGSR_OFF_CONTROL 12'h820
`define UGSR_STATUS_RESET 32'h0000_0400
`define UGSR_EVENT_MASK 32'h0000_00bb
`define UGSR_SETCLR_MASK 32'h0000_02bb
`define UGSR_BIT_IDT 0
`define UGSR_BIT_VBUST 1
`define UGSR_BIT_VBERR 3
`define UGSR_BIT_BCERR 4
`define UGSR_BIT_ROLEX 5
`define UGSR_BIT_STO 7
`define UGSR_BIT_SUPPLY_RQ 9
`define UGSR_BIT_ID 10
`define UGSR_BIT_VBUS 11
`define UGSR_BIT_SPEED_LO 12
`define UGSR_BIT_CLKOK 14
`define UGSR_CTL_POL 13
`define UGSR_CTL_HWC 8
`define UGSR_CTL_ENABLE 15
`define UGSR_CTL_FREEZE 14
`define UGSR_CTL_MASK 32'h0000_e1bb
`endif

/* File: ugsr_pkg.sv */
package ugsr_pkg;
  typedef enum logic [1:0] {UGSR_FULL, UGSR_LOW, UGSR_HIGH, UGSR_RSVD} ugsr_speed_t;
  typedef struct packed {
    logic phy_clock_valid;
    ugsr_speed_t speed;
    logic vbus_level;
    logic id_pin;
  } ugsr_pins_t;
  typedef struct packed {
    logic suspend_timeout;
    logic role_swap;
    logic b_connect_error;
    logic vbus_error;
  } ugsr_events_t;
endpackage

/* File: ugsr_top.sv */
`timescale 1ns/100ps
`include "ugsr_defs.svh"
module ugsr_top
  import ugsr_pkg::*;
#(
  parameter logic [11:0] VERSION = 12'h001,
  parameter logic [3:0] VARIANT = 4'h0,
  parameter logic [6:0] HB_ISO_SUPPORT = 7'h00,
  parameter logic PHY_BUS_WIDTH = 1'b1,
  parameter logic BUFFER_BYTE_WRITE = 1'b1,
  parameter logic [2:0] BUFFER_SIZE_CODE = 3'h3,
  parameter logic [3:0] DMA_FIFO_DEPTH = 4'h0,
  parameter logic DMA_LENGTH_WIDTH = 1'b0,
  parameter logic [2:0] DMA_CHANNEL_COUNT = 3'h7,
  parameter logic [3:0] ENDPOINT_COUNT_MAX = 4'h8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`UGSR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin and core state
  input wire ugsr_pins_t pins,
  input wire ugsr_events_t events,
  // Outputs
  output logic supply_enable_out,
  output logic usb_irq
);

  logic [31:0] flags_reg, flags_next;
  logic [31:0] ctl_reg, ctl_next;
  logic [31:0] prdata_reg, prdata_next;
  logic vbus_prev_reg, vbus_prev_next;
  logic id_prev_reg, id_prev_next;
  logic supply_out_reg, supply_out_next;
  logic wr_en, rd_en;
  logic [31:0] hw_set;
  logic [31:0] status_view;
  logic supply_hw_ctrl_disable, supply_out_polarity;

  function automatic logic hit(input logic [`UGSR_ADDR_W-1:0] a, input logic [`UGSR_ADDR_W-1:0] off);
    return a == off;
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign supply_hw_ctrl_disable = ctl_reg[`UGSR_CTL_HWC];
  assign supply_out_polarity = ctl_reg[`UGSR_CTL_POL];

  // Edge detectors run on the system clock, which never freezes here
  always_comb begin
    hw_set = 32'h0;
    hw_set[`UGSR_BIT_VBUST] = pins.vbus_level != vbus_prev_reg;
    hw_set[`UGSR_BIT_IDT] = pins.id_pin != id_prev_reg;
    hw_set[`UGSR_BIT_VBERR] = events.vbus_error;
    hw_set[`UGSR_BIT_BCERR] = events.b_connect_error;
    hw_set[`UGSR_BIT_ROLEX] = events.role_swap;
    hw_set[`UGSR_BIT_STO] = events.suspend_timeout;
  end

  always_comb begin
    flags_next = flags_reg;
    ctl_next = ctl_reg;
    vbus_prev_next = pins.vbus_level;
    id_prev_next = pins.id_pin;
    if (wr_en) begin
      if (hit(paddr, `UGSR_OFF_CLEAR)) begin
        flags_next = flags_next & ~(pwdata & `UGSR_SETCLR_MASK);
      end else if (hit(paddr, `UGSR_OFF_SET)) begin
        flags_next = flags_next | (pwdata & `UGSR_SETCLR_MASK);
      end else if (hit(paddr, `UGSR_OFF_CONTROL)) begin
        ctl_next = pwdata & `UGSR_CTL_MASK;
      end
    end
    // Supply error drops the request unless hardware control is off
    if (events.vbus_error && !supply_hw_ctrl_disable) begin
      flags_next[`UGSR_BIT_SUPPLY_RQ] = 1'b0;
    end
    // Hardware events win over a simultaneous clear
    flags_next = flags_next | hw_set;
  end

  always_comb begin
    status_view = flags_reg & `UGSR_SETCLR_MASK;
    status_view[`UGSR_BIT_CLKOK] = pins.phy_clock_valid;
    status_view[`UGSR_BIT_SPEED_LO +: 2] = pins.speed;
    status_view[`UGSR_BIT_VBUS] = pins.vbus_level;
    status_view[`UGSR_BIT_ID] = pins.id_pin;
  end

  always_comb begin
    prdata_next = prdata_reg;
    if (rd_en) begin
      if (hit(paddr, `UGSR_OFF_STATUS)) begin
        prdata_next = status_view;
      end else if (hit(paddr, `UGSR_OFF_VERSION)) begin
        prdata_next = {12'h0, VARIANT, 4'h0, VERSION};
      end else if (hit(paddr, `UGSR_OFF_FEATURES)) begin
        prdata_next = {8'h0, HB_ISO_SUPPORT, PHY_BUS_WIDTH, BUFFER_BYTE_WRITE, BUFFER_SIZE_CODE,
                       DMA_FIFO_DEPTH, DMA_LENGTH_WIDTH, DMA_CHANNEL_COUNT, ENDPOINT_COUNT_MAX};
      end else if (hit(paddr, `UGSR_OFF_CONTROL)) begin
        prdata_next = ctl_reg;
      end else begin
        prdata_next = 32'h0;
      end
    end
  end

  always_comb begin
    supply_out_next = flags_next[`UGSR_BIT_SUPPLY_RQ] ^ ctl_next[`UGSR_CTL_POL];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flags_reg <= `UGSR_STATUS_RESET & `UGSR_SETCLR_MASK;
      ctl_reg <= 32'h0;
      prdata_reg <= 32'h0;
      vbus_prev_reg <= 1'b0;
      id_prev_reg <= 1'b1;
      supply_out_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      ctl_reg <= ctl_next;
      prdata_reg <= prdata_next;
      vbus_prev_reg <= vbus_prev_next;
      id_prev_reg <= id_prev_next;
      supply_out_reg <= supply_out_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = 1'b0;
  assign supply_enable_out = supply_out_reg;
  assign usb_irq = |(flags_reg & ctl_reg & `UGSR_EVENT_MASK);

  logic first_cycle_reg;
  always_ff @(posedge sys_clk) begin
    first_cycle_reg <= !rst_n;
  end

  default clocking dflt_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence clr_vbust_s;
    wr_en && hit(paddr, `UGSR_OFF_CLEAR) && pwdata[`UGSR_BIT_VBUST] && !hw_set[`UGSR_BIT_VBUST];
  endsequence
  sequence set_rq_s;
    wr_en && hit(paddr, `UGSR_OFF_SET) && pwdata[`UGSR_BIT_SUPPLY_RQ] && !events.vbus_error;
  endsequence

  vbus_edge_flag_a: assert property (!first_cycle_reg && pins.vbus_level != $past(pins.vbus_level)
    |=> flags_reg[`UGSR_BIT_VBUST]) else $error("supply change not flagged");
  id_edge_flag_a: assert property (!first_cycle_reg && pins.id_pin != $past(pins.id_pin)
    |=> flags_reg[`UGSR_BIT_IDT]) else $error("id change not flagged");
  clear_write_a: assert property (clr_vbust_s |=> !flags_reg[`UGSR_BIT_VBUST])
    else $error("clear write failed");
  set_request_a: assert property (set_rq_s |=> flags_reg[`UGSR_BIT_SUPPLY_RQ] ##0
    supply_enable_out == !supply_out_polarity) else $error("supply request set failed");
  supply_error_drop_a: assert property (events.vbus_error && !supply_hw_ctrl_disable
    |=> !flags_reg[`UGSR_BIT_SUPPLY_RQ] && flags_reg[`UGSR_BIT_VBERR]) else $error("supply error not handled");
  hwc_error_flag_a: assert property (events.vbus_error && supply_hw_ctrl_disable
    |=> flags_reg[`UGSR_BIT_VBERR]) else $error("error flag missing");
  role_swap_irq_a: assert property (events.role_swap && ctl_reg[`UGSR_BIT_ROLEX] && ctl_next[`UGSR_BIT_ROLEX]
    |=> usb_irq) else $error("role swap irq missing");
  status_read_a: assert property (rd_en && hit(paddr, `UGSR_OFF_STATUS)
    |=> prdata[`UGSR_BIT_ID] == $past(pins.id_pin) && prdata[`UGSR_BIT_CLKOK] == $past(pins.phy_clock_valid))
    else $error("status read wrong");
  setclr_read_zero_a: assert property (rd_en && (hit(paddr, `UGSR_OFF_SET) || hit(paddr, `UGSR_OFF_CLEAR))
    |=> prdata == 32'h0) else $error("set or clear read nonzero");
  irq_idle_a: assert property ((flags_reg & ctl_reg & `UGSR_EVENT_MASK) == 32'h0 |-> !usb_irq)
    else $error("irq without cause");

endmodule

/* File: ugsr_phy_model.sv */
`timescale 1ns/100ps
module ugsr_phy_model
  import ugsr_pkg::*;
(
  // Bench commands
  input wire logic sys_clk,
  input wire logic clk_ok,
  input wire ugsr_speed_t speed,
  input wire logic vbus_hi,
  input wire logic id_hi,
  input wire logic [3:0] ev_req,
  // Toward the design
  output ugsr_pins_t pins,
  output ugsr_events_t events
);
  initial begin
    pins = '0;
    events = '0;
  end
  // Pads move on the edge through nonblocking updates, after the design has sampled them
  always @(posedge sys_clk) begin
    pins <= '{clk_ok, speed, vbus_hi, id_hi};
    events <= ev_req;
  end
endmodule

/* File: usb_otg_general_status_regs_tb.sv */
`timescale 1ns/100ps
`include "ugsr_defs.svh"
module usb_otg_general_status_regs_tb;
  import ugsr_pkg::*;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, supply_enable_out, usb_irq;
  logic clk_ok = 0, vbus_hi = 0, id_hi = 1;
  logic [3:0] ev = '0;
  ugsr_speed_t speed = UGSR_FULL;
  ugsr_pins_t pins;
  ugsr_events_t events;
  int failures = 0, checks = 0;
  ugsr_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .events(events), .supply_enable_out(supply_enable_out), .usb_irq(usb_irq));
  ugsr_phy_model phy_u (.sys_clk(sys_clk), .clk_ok(clk_ok), .speed(speed), .vbus_hi(vbus_hi),
    .id_hi(id_hi), .ev_req(ev), .pins(pins), .events(events));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task test_done;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle edge at the end so back-to-back calls never drive psel twice at once
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    r = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, '0);
    chk(r, e);
  endtask
  task pulse(input logic [3:0] e);
    ev <= e;
    @(posedge sys_clk);
    ev <= '0;
    repeat (3) @(posedge sys_clk);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    rd(`UGSR_OFF_STATUS, 32'h0000_0400);
    rd(`UGSR_OFF_CLEAR, 32'h0);
    rd(`UGSR_OFF_SET, 32'h0);
    rd(`UGSR_OFF_VERSION, 32'h0000_0001);
    rd(`UGSR_OFF_FEATURES, 32'h0001_b078);
    rd(12'h810, 32'h0);
    clk_ok <= 1;
    for (int s = 3; s >= 0; s--) begin
      speed <= ugsr_speed_t'(s);
      repeat (2) @(posedge sys_clk);
      rd(`UGSR_OFF_STATUS, 32'h0000_4400 | (32'(s) << 12));
    end
    // Pin moves while frozen must still be caught
    apb(1, `UGSR_OFF_CONTROL, 32'h0000_4000);
    id_hi <= 0;
    vbus_hi <= 1;
    repeat (3) @(posedge sys_clk);
    rd(`UGSR_OFF_STATUS, 32'h0000_4803);
    apb(1, `UGSR_OFF_CONTROL, 32'h0000_0003);
    chk({31'h0, usb_irq}, 32'h1);
    apb(1, `UGSR_OFF_CLEAR, 32'h0000_0003);
    chk({31'h0, usb_irq}, 32'h0);
    rd(`UGSR_OFF_STATUS, 32'h0000_4800);
    apb(1, `UGSR_OFF_SET, 32'h0000_02bb);
    rd(`UGSR_OFF_STATUS, 32'h0000_4abb);
    chk({31'h0, supply_enable_out}, 32'h1);
    apb(1, `UGSR_OFF_CLEAR, 32'h0);
    apb(1, `UGSR_OFF_CLEAR, 32'h0000_00b8);
    rd(`UGSR_OFF_STATUS, 32'h0000_4a03);
    apb(1, `UGSR_OFF_CONTROL, 32'h0000_2000);
    @(posedge sys_clk);
    chk({31'h0, supply_enable_out}, 32'h0);
    apb(1, `UGSR_OFF_CONTROL, 32'h0000_0008);
    pulse(4'b0001);
    rd(`UGSR_OFF_STATUS, 32'h0000_480b);
    chk({31'h0, supply_enable_out}, 32'h0);
    chk({31'h0, usb_irq}, 32'h1);
    apb(1, `UGSR_OFF_CLEAR, 32'h0000_00ff);
    apb(1, `UGSR_OFF_CONTROL, 32'h0000_0100);
    apb(1, `UGSR_OFF_SET, 32'h0000_0200);
    pulse(4'b0001);
    rd(`UGSR_OFF_STATUS, 32'h0000_4a08);
    chk({31'h0, supply_enable_out}, 32'h1);
    apb(1, `UGSR_OFF_CONTROL, 32'h0000_01b0);
    pulse(4'b1110);
    rd(`UGSR_OFF_STATUS, 32'h0000_4ab8);
    chk({31'h0, usb_irq}, 32'h1);
    test_done;
  end
endmodule
